// file: rtl/vcu_pkg.sv
package vcu_pkg;
   localparam int unsigned CLK_HZ = 50_000_000;
   localparam int unsigned DEFAULT_BAUD = 115_200;
   localparam int unsigned MIN_BAUD = 9_600;
   localparam int unsigned MAX_BAUD = 921_600;
   localparam int unsigned SOCKET_PORT = 4_901;
   localparam int unsigned BAUD_W = 20;
   localparam int unsigned NUM_W = 26;
   localparam int unsigned CYC_W = 16;
   localparam int unsigned DATA_BITS = 8;
   localparam int unsigned FRAME_BITS = DATA_BITS + 2;
   localparam int unsigned RX_DEPTH = 16;
   localparam logic [CYC_W-1:0] DEFAULT_BIT_CYCLES = CYC_W'(CLK_HZ / DEFAULT_BAUD);
   localparam logic [NUM_W-1:0] CLK_HZ_NUM = NUM_W'(CLK_HZ);
   localparam logic [BAUD_W-1:0] MIN_BAUD_V = BAUD_W'(MIN_BAUD);
   localparam logic [BAUD_W-1:0] MAX_BAUD_V = BAUD_W'(MAX_BAUD);
   localparam logic [4:0] DIV_STEPS = 5'(NUM_W);
   localparam logic [3:0] FRAME_LAST = 4'(FRAME_BITS - 1);
   localparam logic [3:0] STOP_INDEX = 4'(FRAME_BITS - 1);
   localparam logic LINE_IDLE = 1'h1;
   localparam logic START_LVL = 1'h0;
   localparam logic STOP_LVL = 1'h1;
   // Flow lines are active low at the pins, as on common UARTs
   localparam logic FLOW_ASSERTED = 1'h0;
   localparam logic FLOW_DEASSERTED = 1'h1;
   localparam logic ENABLE_ASSERTED = 1'h1;

   typedef enum logic [1:0] {
      VCU_HS_DISABLED = 2'b00,
      VCU_HS_RTS = 2'b01,
      VCU_HS_CTS = 2'b10,
      VCU_HS_RTSCTS = 2'b11
   } vcu_hs_t;

   typedef struct packed {
      logic valid;
      logic [DATA_BITS-1:0] data;
   } vcu_byte_t;

   typedef struct packed {
      logic [BAUD_W-1:0] baud;
      vcu_hs_t mode;
   } vcu_cfg_t;

   // Throttle of the target through our clear-to-send output
   function automatic logic vcu_rx_hs(input vcu_hs_t m);
      return m == VCU_HS_RTS || m == VCU_HS_RTSCTS;
   endfunction

   // Gating of our transmission on the target's request-to-send
   function automatic logic vcu_tx_hs(input vcu_hs_t m);
      return m == VCU_HS_CTS || m == VCU_HS_RTSCTS;
   endfunction
endpackage

// file: rtl/vcu_sync.sv
`timescale 1ns/1ps
module vcu_sync
   import vcu_pkg::*;
#(
   parameter logic INIT = 1'h1
)
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic din,
   output logic dout
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic q;
   } vcu_sync_st_t;

   vcu_sync_st_t st;
   vcu_sync_st_t next_st;

   always_comb
   begin
      next_st = st;
      next_st.s1 = din;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      // Stage one is never looked at; a change counts once two and three agree
      if (st.s2 == st.s3)
      begin
         next_st.q = st.s3;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         st <= '{s1: INIT, s2: INIT, s3: INIT, q: INIT};
      end
      else
      begin
         st <= next_st;
      end
   end

   assign dout = st.q;
endmodule

// file: rtl/vcu_buf.sv
`timescale 1ns/1ps
module vcu_buf
   import vcu_pkg::*;
#(
   parameter int unsigned W = DATA_BITS,
   parameter int unsigned DEPTH = RX_DEPTH
)
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic wr_valid,
   input wire logic [W-1:0] wr_data,
   output logic wr_ready,
   output logic rd_valid,
   output logic [W-1:0] rd_data,
   input wire logic rd_ready
);
   localparam int unsigned AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0] wr_ptr;
      logic [AW-1:0] rd_ptr;
      logic [AW:0] count;
      logic out_valid;
      logic [W-1:0] out_data;
   } vcu_buf_st_t;

   vcu_buf_st_t st;
   vcu_buf_st_t next_st;
   logic push;
   logic pop;

   assign wr_ready = st.count != (AW+1)'(DEPTH);
   assign push = wr_valid && wr_ready;
   // Output register refills whenever it is empty or being drained
   assign pop = (st.count != '0) && (!st.out_valid || rd_ready);

   always_comb
   begin
      next_st = st;
      if (push)
      begin
         next_st.mem[st.wr_ptr] = wr_data;
         next_st.wr_ptr = (st.wr_ptr == AW'(DEPTH - 1)) ? '0 : st.wr_ptr + AW'(1);
      end
      if (pop)
      begin
         next_st.out_data = st.mem[st.rd_ptr];
         next_st.out_valid = 1'b1;
         next_st.rd_ptr = (st.rd_ptr == AW'(DEPTH - 1)) ? '0 : st.rd_ptr + AW'(1);
      end
      else if (rd_ready)
      begin
         next_st.out_valid = 1'b0;
      end
      next_st.count = st.count + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign rd_valid = st.out_valid;
   assign rd_data = st.out_data;
endmodule

// file: rtl/vcu_bridge.sv
// Overview of operation
// - After reset the link runs 115200 baud, 8N1, no flow control.
// - Configured rate may be anything from 9600 to 921600 bit/s.
// - Each of the two flow control lines is enabled on its own.
// - With receive handshake on, clear-to-send is deasserted while the input buffer is full.
// - With transmit handshake on, sending waits while target request-to-send is deasserted.
// - A character in progress completes; the target takes one more after dropping request.
// - With transmit handshake off, target request-to-send is ignored.
// - Disabled mode: clear-to-send undriven, request-to-send ignored.
// - Receive-only mode: clear-to-send throttles the target, request-to-send ignored.
// - Transmit-only mode: clear-to-send undriven, sending only while request is asserted.
// - Combined mode: throttle via clear-to-send and gate sending on request-to-send.
// - Only one host path carries data; a connected socket silences the USB path.
// - Target bytes go to the active host path; host bytes go to the target.
`timescale 1ns/1ps
module vcu_bridge
   import vcu_pkg::*;
#(
   parameter int unsigned BUF_DEPTH = RX_DEPTH
)
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic cfg_write,
   input wire vcu_cfg_t cfg,
   output logic cfg_busy,
   output logic [CYC_W-1:0] bit_cycles,
   output vcu_hs_t hs_mode,
   input wire logic target_txd,
   output logic target_rxd,
   input wire logic target_rts_n,
   output logic target_cts_n,
   output logic target_cts_oe_n,
   input wire logic target_enable,
   input wire logic socket_connected,
   input wire vcu_byte_t usb_in,
   output logic usb_in_ready,
   output vcu_byte_t usb_out,
   input wire logic usb_out_ready,
   input wire vcu_byte_t sock_in,
   output logic sock_in_ready,
   output vcu_byte_t sock_out,
   input wire logic sock_out_ready,
   output logic rx_overrun,
   output logic rx_frame_err
);
   typedef struct packed {
      logic [CYC_W-1:0] bit_cycles;
      vcu_hs_t mode;
      logic div_busy;
      logic [4:0] div_step;
      logic [NUM_W-1:0] div_num;
      logic [BAUD_W:0] div_rem;
      logic [NUM_W-1:0] div_quo;
      logic [BAUD_W-1:0] div_den;
      vcu_hs_t div_mode;
      logic tx_busy;
      logic [FRAME_BITS-1:0] tx_shift;
      logic [3:0] tx_bit;
      logic [CYC_W-1:0] tx_tick;
      logic txd;
      logic rx_busy;
      logic [3:0] rx_bit;
      logic [CYC_W-1:0] rx_tick;
      logic [DATA_BITS-1:0] rx_shift;
      logic rx_push;
      logic [DATA_BITS-1:0] rx_data;
      logic overrun;
      logic frame_err;
      logic cts_lvl;
      logic cts_oe_n;
      logic sock_sel;
   } vcu_st_t;

   vcu_st_t st;
   vcu_st_t next_st;
   logic [2:0] pin_raw;
   logic [2:0] pin_sync;
   logic rxd_s;
   logic rts_n_s;
   logic enable_s;
   logic buf_wr_ready;
   logic buf_rd_valid;
   logic [DATA_BITS-1:0] buf_rd_data;
   logic buf_rd_ready;
   logic tx_allowed;
   logic tx_take;
   vcu_byte_t host_in;
   logic [BAUD_W-1:0] baud_clamped;
   logic [BAUD_W:0] div_trial;

   assign pin_raw = {target_enable, target_rts_n, target_txd};

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++)
      begin : g_pin
         vcu_sync #(
            .INIT(gi == 2 ? ~ENABLE_ASSERTED : LINE_IDLE)
         ) u_sync (
            .mclk(mclk),
            .reset(reset),
            .din(pin_raw[gi]),
            .dout(pin_sync[gi])
         );
      end
   endgenerate

   assign rxd_s = pin_sync[0];
   assign rts_n_s = pin_sync[1];
   assign enable_s = pin_sync[2] == ENABLE_ASSERTED;

   vcu_buf #(
      .W(DATA_BITS),
      .DEPTH(BUF_DEPTH)
   ) u_rx_buf (
      .mclk(mclk),
      .reset(reset),
      .wr_valid(st.rx_push),
      .wr_data(st.rx_data),
      .wr_ready(buf_wr_ready),
      .rd_valid(buf_rd_valid),
      .rd_data(buf_rd_data),
      .rd_ready(buf_rd_ready)
   );

   // Out-of-range rates are pinned to the nearest supported end
   always_comb
   begin
      if (cfg.baud < MIN_BAUD_V)
      begin
         baud_clamped = MIN_BAUD_V;
      end
      else if (cfg.baud > MAX_BAUD_V)
      begin
         baud_clamped = MAX_BAUD_V;
      end
      else
      begin
         baud_clamped = cfg.baud;
      end
   end

   // Path choice is registered so a byte never splits across paths mid-cycle
   assign host_in = st.sock_sel ? sock_in : usb_in;
   // Ignores request-to-send unless transmit handshake is on
   assign tx_allowed = !vcu_tx_hs(st.mode) || rts_n_s == FLOW_ASSERTED;
   assign tx_take = !st.tx_busy && tx_allowed && enable_s && host_in.valid;
   assign usb_in_ready = !st.sock_sel && !st.tx_busy && tx_allowed && enable_s;
   assign sock_in_ready = st.sock_sel && !st.tx_busy && tx_allowed && enable_s;
   assign buf_rd_ready = st.sock_sel ? sock_out_ready : usb_out_ready;
   assign usb_out.valid = buf_rd_valid && !st.sock_sel;
   assign usb_out.data = buf_rd_data;
   assign sock_out.valid = buf_rd_valid && st.sock_sel;
   assign sock_out.data = buf_rd_data;
   assign div_trial = {st.div_rem[BAUD_W-1:0], st.div_num[NUM_W-1]};

   always_comb
   begin
      next_st = st;
      next_st.rx_push = 1'b0;
      next_st.sock_sel = socket_connected;
      // Cleared first, so a byte lost in the same cycle still sets it
      if (cfg_write)
      begin
         next_st.overrun = 1'b0;
      end

      // Bit time is clock over baud, by restoring division one bit a cycle
      if (cfg_write && !st.div_busy)
      begin
         next_st.div_busy = 1'b1;
         next_st.div_step = '0;
         next_st.div_num = CLK_HZ_NUM;
         next_st.div_rem = '0;
         next_st.div_quo = '0;
         next_st.div_den = baud_clamped;
         next_st.div_mode = cfg.mode;
      end
      else if (st.div_busy)
      begin
         next_st.div_num = {st.div_num[NUM_W-2:0], 1'b0};
         if (div_trial >= {1'b0, st.div_den})
         begin
            next_st.div_rem = div_trial - {1'b0, st.div_den};
            next_st.div_quo = {st.div_quo[NUM_W-2:0], 1'b1};
         end
         else
         begin
            next_st.div_rem = div_trial;
            next_st.div_quo = {st.div_quo[NUM_W-2:0], 1'b0};
         end
         next_st.div_step = st.div_step + 5'h01;
         if (st.div_step == DIV_STEPS - 5'h01)
         begin
            next_st.div_busy = 1'b0;
            next_st.bit_cycles = next_st.div_quo[CYC_W-1:0];
            next_st.mode = st.div_mode;
         end
      end

      // Transmitter; a started frame always runs to its stop bit
      if (tx_take)
      begin
         next_st.tx_busy = 1'b1;
         next_st.tx_shift = {STOP_LVL, host_in.data, START_LVL};
         next_st.tx_bit = '0;
         next_st.tx_tick = st.bit_cycles - CYC_W'(1);
         next_st.txd = START_LVL;
      end
      else if (st.tx_busy)
      begin
         if (st.tx_tick == '0)
         begin
            if (st.tx_bit == FRAME_LAST)
            begin
               next_st.tx_busy = 1'b0;
               next_st.txd = LINE_IDLE;
            end
            else
            begin
               next_st.tx_bit = st.tx_bit + 4'h1;
               next_st.tx_shift = {1'b0, st.tx_shift[FRAME_BITS-1:1]};
               next_st.txd = st.tx_shift[1];
               next_st.tx_tick = st.bit_cycles - CYC_W'(1);
            end
         end
         else
         begin
            next_st.tx_tick = st.tx_tick - CYC_W'(1);
         end
      end

      // Receiver samples mid-bit once the idle line is seen at the start level
      if (!st.rx_busy)
      begin
         if (enable_s && rxd_s == START_LVL)
         begin
            next_st.rx_busy = 1'b1;
            next_st.rx_bit = '0;
            next_st.rx_tick = {1'b0, st.bit_cycles[CYC_W-1:1]};
         end
      end
      else if (st.rx_tick != '0)
      begin
         next_st.rx_tick = st.rx_tick - CYC_W'(1);
      end
      else
      begin
         next_st.rx_tick = st.bit_cycles - CYC_W'(1);
         next_st.rx_bit = st.rx_bit + 4'h1;
         if (st.rx_bit == '0)
         begin
            // A glitch shorter than half a bit is not a start
            if (rxd_s != START_LVL)
            begin
               next_st.rx_busy = 1'b0;
            end
         end
         else if (st.rx_bit == STOP_INDEX)
         begin
            next_st.rx_busy = 1'b0;
            if (rxd_s == STOP_LVL)
            begin
               next_st.frame_err = 1'b0;
               next_st.rx_data = st.rx_shift;
               if (buf_wr_ready)
               begin
                  next_st.rx_push = 1'b1;
               end
               else
               begin
                  // No room in the buffer, with or without a throttle; the byte is lost
                  next_st.overrun = 1'b1;
               end
            end
            else
            begin
               next_st.frame_err = 1'b1;
            end
         end
         else
         begin
            next_st.rx_shift = {rxd_s, st.rx_shift[DATA_BITS-1:1]};
         end
      end

      // Clear-to-send is only driven in the modes with receive handshake
      if (vcu_rx_hs(st.mode))
      begin
         next_st.cts_oe_n = 1'b0;
         next_st.cts_lvl = buf_wr_ready ? FLOW_ASSERTED : FLOW_DEASSERTED;
      end
      else
      begin
         next_st.cts_oe_n = 1'b1;
         next_st.cts_lvl = FLOW_DEASSERTED;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         st <= '0;
         st.bit_cycles <= DEFAULT_BIT_CYCLES;
         st.mode <= VCU_HS_DISABLED;
         st.div_mode <= VCU_HS_DISABLED;
         st.txd <= LINE_IDLE;
         st.cts_lvl <= FLOW_DEASSERTED;
         st.cts_oe_n <= 1'b1;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign target_rxd = st.txd;
   assign target_cts_n = st.cts_lvl;
   assign target_cts_oe_n = st.cts_oe_n;
   assign cfg_busy = st.div_busy;
   assign bit_cycles = st.bit_cycles;
   assign hs_mode = st.mode;
   assign rx_overrun = st.overrun;
   assign rx_frame_err = st.frame_err;
endmodule

// file: bench/vcu_checker.sv
`timescale 1ns/1ps
module vcu_checker
   import vcu_pkg::*;
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic cfg_write,
   input wire logic cfg_busy,
   input wire logic [CYC_W-1:0] bit_cycles,
   input wire vcu_hs_t hs_mode,
   input wire logic target_rxd,
   input wire logic target_rts_n,
   input wire logic target_cts_oe_n,
   input wire logic socket_connected,
   input wire vcu_byte_t usb_in,
   input wire logic usb_in_ready,
   input wire vcu_byte_t usb_out,
   input wire vcu_byte_t sock_in,
   input wire logic sock_in_ready
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (reset);

   sequence s_take;
      (usb_in.valid && usb_in_ready) || (sock_in.valid && sock_in_ready);
   endsequence
   // Covers the worst case of the 3-4 cycle synchroniser lag
   sequence s_rts_off;
      target_rts_n [*5];
   endsequence

   a_idle_reset: assert property ($past(reset) |-> target_rxd && target_cts_oe_n)
      else $error("line not idle after reset");
   a_busy_len: assert property ($rose(cfg_busy) |-> ##25 cfg_busy ##1 !cfg_busy)
      else $error("rate computation length wrong");
   a_cfg_take: assert property (cfg_write && !cfg_busy |=> cfg_busy)
      else $error("config write not taken");
   a_rate_hold: assert property (!cfg_busy && !$past(cfg_busy) |-> $stable(bit_cycles))
      else $error("bit time moved without config");
   a_cts_off: assert property (!hs_mode[0] && !$past(hs_mode[0]) |-> target_cts_oe_n)
      else $error("clear-to-send driven without rx handshake");
   a_cts_on: assert property (hs_mode[0] && $past(hs_mode[0]) |-> !target_cts_oe_n)
      else $error("clear-to-send not driven");
   a_one_path: assert property (socket_connected && $past(socket_connected)
      |-> !usb_in_ready && !usb_out.valid)
      else $error("usb path active with socket");
   a_start_bit: assert property (s_take |=> !target_rxd && !usb_in_ready && !sock_in_ready)
      else $error("no start bit after take");
   a_rts_gate: assert property (s_rts_off ##0 hs_mode[1] |-> !usb_in_ready && !sock_in_ready)
      else $error("sending while request deasserted");
endmodule

bind vcu_bridge vcu_checker u_chk (.mclk, .reset, .cfg_write, .cfg_busy, .bit_cycles, .hs_mode,
   .target_rxd, .target_rts_n, .target_cts_oe_n, .socket_connected, .usb_in, .usb_in_ready,
   .usb_out, .sock_in, .sock_in_ready);

// file: bench/vcu_target.sv
`timescale 1ns/1ps
module vcu_target
#(
   parameter int BC = 54
)
(
   input wire logic mclk,
   input wire logic rxd,
   input wire logic cts_n,
   input wire logic cts_oe_n,
   output logic txd,
   output logic [7:0] got,
   output int n_got
);
   logic [7:0] sh;

   initial
   begin
      txd = 1'h1;
      n_got = 0;
   end

   // Always has room, so the extra character after a throttle is taken
   always
   begin
      @(negedge rxd);
      repeat (BC / 2) @(posedge mclk);
      for (int i = 0; i < 8; i++)
      begin
         repeat (BC) @(posedge mclk);
         sh[i] = rxd;
      end
      repeat (BC) @(posedge mclk);
      got = sh;
      n_got++;
   end

   task automatic send(input logic [7:0] b);
      logic [9:0] f;
      f = {1'h1, b, 1'h0};
      while (!cts_oe_n && cts_n)
         @(posedge mclk);
      for (int i = 0; i < 10; i++)
      begin
         @(posedge mclk);
         txd <= f[i];
         repeat (BC - 1) @(posedge mclk);
      end
   endtask
endmodule

// file: bench/vcom_uart_flow_bridge_bench.sv
`timescale 1ns/1ps
module vcom_uart_flow_bridge_bench
   import vcu_pkg::*;
();
   typedef struct packed {
      logic [BAUD_W-1:0] baud;
      vcu_hs_t mode;
      logic [CYC_W-1:0] cyc;
   } vcu_row_t;
   vcu_row_t rows [5] = '{'{20'h1C200, VCU_HS_RTS, 16'h01B2}, '{20'h02580, VCU_HS_CTS, 16'h1458},
      '{20'h003E8, VCU_HS_RTSCTS, 16'h1458}, '{20'hE1000, VCU_HS_CTS, 16'h0036},
      '{20'hF4240, VCU_HS_DISABLED, 16'h0036}};
   logic mclk = 1'h0;
   logic reset = 1'h1;
   logic cfg_write = 1'h0;
   vcu_cfg_t cfg = '0;
   logic rts_n = 1'h1;
   logic en = 1'h1;
   logic sock = 1'h0;
   vcu_byte_t uin = '0;
   vcu_byte_t sin = '0;
   logic uordy = 1'h0;
   logic sordy = 1'h0;
   logic txd, busy, rxd, cts_n, oe_n, uirdy, sirdy, ovr, ferr;
   logic [CYC_W-1:0] bc;
   vcu_hs_t mode;
   vcu_byte_t uout, sout;
   logic [7:0] got;
   int n_got;
   int n_mismatch = 0;
   int checks_done = 0;
   int cyc = 0;

   always #10 mclk = ~mclk;

   vcu_bridge u_dut (.mclk, .reset, .cfg_write, .cfg, .cfg_busy(busy), .bit_cycles(bc), .hs_mode(mode),
      .target_txd(txd), .target_rxd(rxd), .target_rts_n(rts_n), .target_cts_n(cts_n),
      .target_cts_oe_n(oe_n), .target_enable(en), .socket_connected(sock), .usb_in(uin),
      .usb_in_ready(uirdy), .usb_out(uout), .usb_out_ready(uordy), .sock_in(sin), .sock_in_ready(sirdy),
      .sock_out(sout), .sock_out_ready(sordy), .rx_overrun(ovr), .rx_frame_err(ferr));

   vcu_target u_tgt (.mclk, .rxd, .cts_n, .cts_oe_n(oe_n), .txd, .got, .n_got);

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic clk(input int n);
      repeat (n) @(posedge mclk);
   endtask

   task automatic config_set(input logic [BAUD_W-1:0] b, input vcu_hs_t m);
      @(posedge mclk);
      cfg_write <= 1'h1;
      cfg <= '{b, m};
      @(posedge mclk);
      cfg_write <= 1'h0;
      clk(2);
      for (int i = 0; i < 40 && busy !== 1'h0; i++)
         @(posedge mclk);
      clk(2);
   endtask

   // Holds the byte until ready is seen high, then drops valid after that edge
   task automatic tx_check(input logic s, input logic [7:0] b, input logic r);
      int n0;
      n0 = n_got;
      @(posedge mclk);
      if (s)
         sin <= '{1'h1, b};
      else
         uin <= '{1'h1, b};
      for (int i = 0; i < 200; i++)
      begin
         @(negedge mclk);
         if ((s ? sirdy : uirdy) === 1'h1)
            break;
      end
      @(posedge mclk);
      sin.valid <= 1'h0;
      uin.valid <= 1'h0;
      rts_n <= r;
      for (int i = 0; i < 1000 && n_got == n0; i++)
         @(posedge mclk);
      chk(got, b);
   endtask

   task automatic host_rx(input logic s, input logic [7:0] b);
      for (int i = 0; i < 2000; i++)
      begin
         @(negedge mclk);
         if ((s ? sout.valid : uout.valid) === 1'h1)
            break;
      end
      chk(s ? sout.data : uout.data, b);
      @(posedge mclk);
      uordy <= 1'h1;
      sordy <= 1'h1;
      @(posedge mclk);
      uordy <= 1'h0;
      sordy <= 1'h0;
   endtask

   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         n_mismatch++;
         stop_test();
      end
   end

   initial
   begin
      clk(3);
      reset <= 1'h0;
      clk(4);
      chk(bc, 16'h01B2);
      chk(mode, VCU_HS_DISABLED);
      chk(rxd, 1'h1);
      chk(oe_n, 1'h1);
      $display("reset test done");
      foreach (rows[i])
      begin
         config_set(rows[i].baud, rows[i].mode);
         chk(bc, rows[i].cyc);
         chk(mode, rows[i].mode);
         chk(oe_n, !rows[i].mode[0]);
      end
      $display("table test done");
      tx_check(1'h0, 8'hA5, 1'h1);
      u_tgt.send(8'h3C);
      host_rx(1'h0, 8'h3C);
      chk(ferr, 1'h0);
      $display("usb path test done");
      sock <= 1'h1;
      clk(4);
      chk(uirdy, 1'h0);
      tx_check(1'h1, 8'h5A, 1'h1);
      u_tgt.send(8'hC3);
      chk(uout.valid, 1'h0);
      host_rx(1'h1, 8'hC3);
      sock <= 1'h0;
      clk(4);
      $display("socket test done");
      config_set(20'hE1000, VCU_HS_CTS);
      chk(uirdy, 1'h0);
      rts_n <= 1'h0;
      tx_check(1'h0, 8'h96, 1'h1);
      // Past the stop bit, so only the request line can hold ready low
      clk(40);
      chk(uirdy, 1'h0);
      rts_n <= 1'h0;
      tx_check(1'h0, 8'h69, 1'h0);
      $display("request gate test done");
      config_set(20'hE1000, VCU_HS_RTS);
      // Output register holds one byte beyond the buffer entries
      for (int i = 0; i < 17; i++)
         u_tgt.send(8'(i));
      clk(4);
      chk(cts_n, 1'h1);
      chk(oe_n, 1'h0);
      host_rx(1'h0, 8'h00);
      clk(4);
      chk(cts_n, 1'h0);
      $display("throttle test done");
      config_set(20'hE1000, VCU_HS_DISABLED);
      chk(ovr, 1'h0);
      u_tgt.send(8'hAA);
      u_tgt.send(8'h55);
      clk(4);
      chk(ovr, 1'h1);
      config_set(20'hE1000, VCU_HS_DISABLED);
      chk(ovr, 1'h0);
      $display("overrun test done");
      en <= 1'h0;
      clk(6);
      chk(uirdy, 1'h0);
      en <= 1'h1;
      clk(6);
      chk(uirdy, 1'h1);
      $display("enable test done");
      reset <= 1'h1;
      clk(3);
      reset <= 1'h0;
      clk(4);
      chk(bc, 16'h01B2);
      chk(mode, VCU_HS_DISABLED);
      chk(uout.valid, 1'h0);
      $display("second reset test done");
      stop_test();
   end
endmodule
